// ==== dtp_pkg.sv ====
// Package with register map, field layouts and reset values for the timer.
package dtp_pkg;

   // ****************************************************************
   // Register indices; byte address is four times the index.
   // ****************************************************************
   localparam logic [5:0] IDX_PULSE_B_CTRL  = 6'h11;
   localparam logic [5:0] IDX_PULSE_B_DUTY  = 6'h13;
   localparam logic [5:0] IDX_COUNTER_LOW   = 6'h15;
   localparam logic [5:0] IDX_CONTROL_ONE   = 6'h16;
   localparam logic [5:0] IDX_CONTROL_TWO   = 6'h17;
   localparam logic [5:0] IDX_PULSE_C_DUTY  = 6'h18;
   localparam logic [5:0] IDX_PRESCALE_VAL  = 6'h19;
   localparam logic [5:0] IDX_DUTY_HIGH     = 6'h1A;

   // ****************************************************************
   // Reset values and timer constants.
   // ****************************************************************
   localparam logic [7:0] RST_PULSE_B_CTRL  = 8'h00;
   localparam logic [7:0] RST_CONTROL_ONE   = 8'h00;
   localparam logic [7:0] RST_CONTROL_TWO   = 8'h3F;
   localparam logic [7:0] RST_DUTY_HIGH     = 8'h00;
   localparam logic [7:0] RST_PRESCALE      = 8'hFF;
   localparam logic [9:0] COUNT_ALL_ONES    = 10'h3FF;
   localparam logic [9:0] COUNT_ZERO        = 10'h000;
   localparam logic [1:0] RESP_OKAY         = 2'h0;
   localparam logic [1:0] RESP_SLVERR       = 2'h2;

   // Duty high-bits layout: pulse B, pulse C and counter reload fields.
   localparam int DH_B_LSB   = 0;
   localparam int DH_C_LSB   = 2;
   localparam int DH_CNT_LSB = 6;

   // Pulse B output control register layout.
   typedef struct packed {
      logic       pinEnable;
      logic       activeLow;
      logic [5:0] rsvd;
   } dtp_pulse_ctrl_t;

   // Control register one layout.
   typedef struct packed {
      logic pinEnable;
      logic activeLow;
      logic rsvd;
      logic specialClockSelect;
      logic highOscClockSelect;
      logic oneShotSelect;
      logic reloadSelect;
      logic downTimerRun;
   } dtp_ctrl_one_t;

   // Control register two layout.
   typedef struct packed {
      logic [1:0] rsvd;
      logic       clockSourceSelect;
      logic       extEdgeSelect;
      logic       prescaleDisable_n;
      logic [2:0] prescaleRateField;
   } dtp_ctrl_two_t;

endpackage

// ==== dtp_down_timer.sv ====
// Down timer with prescaler, two pulse-width outputs and AXI4-Lite slave.
`timescale 1ns/10ps

// Functional notes
// - Pulse B active low when polarity set.
// - Pulse B enable routes it to pin two.
// - Pulse B frame from other timer, duty shared.
// - Counter read returns live count value.
// - Counter write loads reload and live count.
// - Timer counts only while run bit set.
// - Non-stop, no reload: underflow loads all ones.
// - Non-stop with reload: underflow loads reload.
// - One-shot counts down once then stops.
// - High oscillator select overrides source select.
// - Special clock select overrides high oscillator.
// - Pulse C active low when polarity set.
// - Pulse C enable routes it to pin four.
// - Prescaler divides by two to the rate+1.
// - Prescaler disable bit is active low enable.
// - Edge select picks falling or rising edge.
// - Source select picks external or instruction clock.
// - Pulse C frame from live count, duty shared.
// - Prescaler value read-only, shows live counter.
module dtp_down_timer #(
   parameter int ADDR_W = 8
) (
   input  wire logic              ref_clk,
   input  wire logic              rst_b,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output      logic              s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output      logic              s_axi_wready,
   output      logic [1:0]        s_axi_bresp,
   output      logic              s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output      logic              s_axi_arready,
   output      logic [31:0]       s_axi_rdata,
   output      logic [1:0]        s_axi_rresp,
   output      logic              s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              instrTick,
   input  wire logic              highOscClk,
   input  wire logic              specialOscClk,
   input  wire logic              externalClockPin,
   input  wire logic [9:0]        otherTimerCount,
   input  wire logic              gpioABitTwoOut,
   input  wire logic              gpioABitTwoOe,
   input  wire logic              gpioABitFourOut,
   input  wire logic              gpioABitFourOe,
   output      logic              portABitTwoOut,
   output      logic              portABitTwoOe,
   output      logic              portABitFourOut,
   output      logic              portABitFourOe
);

   // ****************************************************************
   // Declarations.
   // ****************************************************************
   dtp_pkg::dtp_pulse_ctrl_t pulseBCtrl;
   dtp_pkg::dtp_ctrl_one_t   ctrlOne;
   dtp_pkg::dtp_ctrl_two_t   ctrlTwo;
   logic [7:0]  pulseBDutyLow;
   logic [7:0]  pulseCDutyLow;
   logic [7:0]  dutyHigh;
   logic [9:0]  reloadValue;
   logic [9:0]  count;
   logic [7:0]  prescaleCount;
   logic [2:0]  extSync;
   logic [2:0]  hiSync;
   logic [2:0]  spSync;
   logic        awHeld;
   logic        wHeld;
   logic [5:0]  wrIndex;
   logic [7:0]  wrData;
   logic        wrLane;
   logic        doWrite;
   logic        wrCounter;
   logic        srcTick;
   logic        timerTick;
   logic [7:0]  rateMask;
   logic [9:0]  dutyB;
   logic [9:0]  dutyC;
   logic        pulseB;
   logic        pulseC;
   logic [9:0]  next_count;
   logic [31:0] next_rdata;
   logic        next_rerr;

   // Word index from a byte address; low two bits are ignored.
   function automatic logic [5:0] wordIndex(input logic [ADDR_W-1:0] a);
      return a[7:2];
   endfunction

   // ****************************************************************
   // Pin synchronisers and edge detection.
   // ****************************************************************
   // Bit 0 feeds only bit 1; edges compare the two settled stages.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         extSync <= 3'h0;
         hiSync  <= 3'h0;
         spSync  <= 3'h0;
      end else begin
         extSync <= {extSync[1:0], externalClockPin};
         hiSync  <= {hiSync[1:0], highOscClk};
         spSync  <= {spSync[1:0], specialOscClk};
      end
   end

   // Clock source choice; oscillators are seen as rising-edge ticks.
   always_comb begin
      if (ctrlOne.specialClockSelect) begin
         srcTick = spSync[1] & ~spSync[2];
      end else if (ctrlOne.highOscClockSelect) begin
         srcTick = hiSync[1] & ~hiSync[2];
      end else if (ctrlTwo.clockSourceSelect) begin
         srcTick = ctrlTwo.extEdgeSelect ?
                   (~extSync[1] & extSync[2]) :
                   (extSync[1] & ~extSync[2]);
      end else begin
         srcTick = instrTick;
      end
   end

   // ****************************************************************
   // Prescaler.
   // ****************************************************************
   // Tick out when the low rate+1 bits of the counter are all ones.
   assign rateMask  = 8'((9'h001 << ({1'b0, ctrlTwo.prescaleRateField}
                        + 4'h1)) - 9'h001);
   assign timerTick = ctrlTwo.prescaleDisable_n ? srcTick :
                      (srcTick && ((prescaleCount & rateMask) == rateMask));

   // The counter free-runs on source ticks only while enabled.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         prescaleCount <= dtp_pkg::RST_PRESCALE;
      end else if (!ctrlTwo.prescaleDisable_n && srcTick) begin
         prescaleCount <= prescaleCount + 8'h01;
      end
   end

   // ****************************************************************
   // Register bus, write path.
   // ****************************************************************
   // Address and data are caught separately, in either order.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         awHeld  <= 1'b0;
         wHeld   <= 1'b0;
         wrIndex <= 6'h00;
         wrData  <= 8'h00;
         wrLane  <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld  <= 1'b1;
            wrIndex <= wordIndex(s_axi_awaddr);
         end else if (doWrite) begin
            awHeld <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld  <= 1'b1;
            wrData <= s_axi_wdata[7:0];
            wrLane <= s_axi_wstrb[0];
         end else if (doWrite) begin
            wHeld <= 1'b0;
         end
      end
   end

   assign doWrite   = awHeld && wHeld && !s_axi_bvalid;
   assign wrCounter = doWrite && wrLane &&
                      (wrIndex == dtp_pkg::IDX_COUNTER_LOW);

   // Ready is dropped while a word is held, which back-pressures the master.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= dtp_pkg::RESP_OKAY;
      end else begin
         s_axi_awready <= !awHeld && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !wHeld && !(s_axi_wvalid && s_axi_wready);
         if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wrIndex >= dtp_pkg::IDX_PULSE_B_CTRL &&
                             wrIndex <= dtp_pkg::IDX_DUTY_HIGH &&
                             wrIndex != 6'h12 && wrIndex != 6'h14) ?
                            dtp_pkg::RESP_OKAY : dtp_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Writable registers; the prescaler value register ignores writes.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pulseBCtrl    <= dtp_pkg::RST_PULSE_B_CTRL;
         ctrlOne       <= dtp_pkg::RST_CONTROL_ONE;
         ctrlTwo       <= dtp_pkg::RST_CONTROL_TWO;
         dutyHigh      <= dtp_pkg::RST_DUTY_HIGH;
         pulseBDutyLow <= 8'h00;
         pulseCDutyLow <= 8'h00;
      end else if (doWrite && wrLane) begin
         unique case (wrIndex)
            dtp_pkg::IDX_PULSE_B_CTRL: pulseBCtrl    <= {wrData[7:6], 6'h00};
            dtp_pkg::IDX_PULSE_B_DUTY: pulseBDutyLow <= wrData;
            dtp_pkg::IDX_CONTROL_ONE:  ctrlOne <= {wrData[7:6], 1'b0,
                                                   wrData[4:0]};
            dtp_pkg::IDX_CONTROL_TWO:  ctrlTwo <= {2'h0, wrData[5:0]};
            dtp_pkg::IDX_PULSE_C_DUTY: pulseCDutyLow <= wrData;
            dtp_pkg::IDX_DUTY_HIGH:    dutyHigh      <= wrData;
            default: ;
         endcase
      end
   end

   // ****************************************************************
   // Down counter.
   // ****************************************************************
   // A software write wins over a count tick in the same cycle.
   always_comb begin
      next_count = count;
      if (wrCounter) begin
         next_count = {dutyHigh[dtp_pkg::DH_CNT_LSB +: 2], wrData};
      end else if (ctrlOne.downTimerRun && timerTick) begin
         if (count != dtp_pkg::COUNT_ZERO) begin
            next_count = count - 10'h001;
         end else if (ctrlOne.oneShotSelect) begin
            next_count = count;
         end else if (ctrlOne.reloadSelect) begin
            next_count = reloadValue;
         end else begin
            next_count = dtp_pkg::COUNT_ALL_ONES;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         count       <= dtp_pkg::COUNT_ZERO;
         reloadValue <= dtp_pkg::COUNT_ZERO;
      end else begin
         count <= next_count;
         if (wrCounter) begin
            reloadValue <= next_count;
         end
      end
   end

   // ****************************************************************
   // Register bus, read path.
   // ****************************************************************
   // Pulse B and pulse C low duty registers are write-only and read back as zero.
   always_comb begin
      next_rdata = 32'h0000_0000;
      next_rerr  = 1'b0;
      unique case (wordIndex(s_axi_araddr))
         dtp_pkg::IDX_PULSE_B_CTRL: next_rdata[7:0] = pulseBCtrl;
         dtp_pkg::IDX_PULSE_B_DUTY: next_rdata[7:0] = 8'h00;
         dtp_pkg::IDX_COUNTER_LOW:  next_rdata[9:0] = count;
         dtp_pkg::IDX_CONTROL_ONE:  next_rdata[7:0] = ctrlOne;
         dtp_pkg::IDX_CONTROL_TWO:  next_rdata[7:0] = ctrlTwo;
         dtp_pkg::IDX_PULSE_C_DUTY: next_rdata[7:0] = 8'h00;
         dtp_pkg::IDX_PRESCALE_VAL: next_rdata[7:0] = prescaleCount;
         dtp_pkg::IDX_DUTY_HIGH:    next_rdata[7:0] = dutyHigh;
         default:                   next_rerr = 1'b1;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= dtp_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= next_rerr ? dtp_pkg::RESP_SLVERR :
                                        dtp_pkg::RESP_OKAY;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Pulse outputs and pin routing.
   // ****************************************************************
   // The frame is the other timer count for B and the counter for C; duty bits extend to ten bits.
   assign dutyB  = {dutyHigh[dtp_pkg::DH_B_LSB +: 2], pulseBDutyLow};
   assign dutyC  = {dutyHigh[dtp_pkg::DH_C_LSB +: 2], pulseCDutyLow};
   assign pulseB = (otherTimerCount <= dutyB) ^ pulseBCtrl.activeLow;
   assign pulseC = (count <= dutyC) ^ ctrlOne.activeLow;

   // Pins are registered, so they lag the counter by one cycle.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         portABitTwoOut  <= 1'b0;
         portABitTwoOe   <= 1'b0;
         portABitFourOut <= 1'b0;
         portABitFourOe  <= 1'b0;
      end else begin
         portABitTwoOut  <= pulseBCtrl.pinEnable ? pulseB : gpioABitTwoOut;
         portABitTwoOe   <= pulseBCtrl.pinEnable | gpioABitTwoOe;
         portABitFourOut <= ctrlOne.pinEnable ? pulseC : gpioABitFourOut;
         portABitFourOe  <= ctrlOne.pinEnable | gpioABitFourOe;
      end
   end

   // ****************************************************************
   // Assertions and cover points.
   // ****************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   chk_hold_when_stopped: assert property (
      !ctrlOne.downTimerRun && !wrCounter |=> $stable(count))
      else $error("Counter moved while stopped.");
   chk_underflow_ones: assert property (
      ctrlOne.downTimerRun && timerTick && !wrCounter && count == 10'h000
      && !ctrlOne.oneShotSelect && !ctrlOne.reloadSelect
      |=> count == 10'h3FF)
      else $error("Underflow did not load all ones.");
   chk_underflow_reload: assert property (
      ctrlOne.downTimerRun && timerTick && !wrCounter && count == 10'h000
      && !ctrlOne.oneShotSelect && ctrlOne.reloadSelect
      |=> count == $past(reloadValue))
      else $error("Underflow did not load reload value.");
   chk_one_shot_stop: assert property (
      ctrlOne.oneShotSelect && count == 10'h000 && !wrCounter
      |=> count == 10'h000)
      else $error("One-shot counter left zero.");
   chk_count_write: assert property (
      wrCounter |=> count == reloadValue && count[7:0] == $past(wrData))
      else $error("Counter write not loaded.");
   chk_pin_b_route: assert property (
      pulseBCtrl.pinEnable ##1 pulseBCtrl.pinEnable |-> portABitTwoOe)
      else $error("Pulse B pin not driven.");
   chk_pin_c_polarity: assert property (
      ctrlOne.pinEnable && count > dutyC |=> portABitFourOut ==
      $past(ctrlOne.activeLow))
      else $error("Pulse C inactive level wrong.");
   chk_prescale_bypass: assert property (
      ctrlTwo.prescaleDisable_n |-> timerTick == srcTick
      ##1 $stable(prescaleCount))
      else $error("Bypassed prescaler still active.");
   chk_special_wins: assert property (
      ctrlOne.specialClockSelect && !spSync[1] |-> !srcTick)
      else $error("Special clock did not override.");
   chk_read_holds: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("Read answer dropped early.");

   cov_underflow_ones: cover property (count == 10'h000 ##1 count == 10'h3FF);
   cov_counter_write: cover property (wrCounter);
   cov_prescaled_tick: cover property (!ctrlTwo.prescaleDisable_n
                                       && timerTick);
   cov_pulse_c_on_pin: cover property (ctrlOne.pinEnable && portABitFourOe);

endmodule // dtp_down_timer

// ==== dtp_ext_clock_model.sv ====
// Model of the source that drives the external clock pin.
`timescale 1ns/10ps
module dtp_ext_clock_model (
   input  wire logic       ref_clk,
   input  wire logic       rst_b,
   input  wire logic       go,
   input  wire logic [3:0] nPulse,
   output      logic       externalClockPin,
   output      logic       busy
);
   logic [3:0] left;
   logic [2:0] phase;

   // Bursts of pulses, four cycles high and four low, idle low between.
   // The pin stands still outside a burst, so no stray edge can count.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         busy             <= 1'b0;
         left             <= 4'h0;
         phase            <= 3'h0;
         externalClockPin <= 1'b0;
      end else if (!busy && go) begin
         busy  <= 1'b1;
         left  <= nPulse;
         phase <= 3'h0;
      end else if (busy) begin
         phase            <= phase + 3'h1;
         externalClockPin <= (phase < 3'h4);
         if (phase == 3'h7) begin
            left <= left - 4'h1;
            if (left == 4'h1) busy <= 1'b0;
         end
      end
   end
endmodule // dtp_ext_clock_model

// ==== test_down_timer_with_prescaler_and_pwm.sv ====
// Self-checking testbench for the down timer with prescaler and pulses.
`timescale 1ns/10ps
module test_down_timer_with_prescaler_and_pwm;
   // ****
   // Signals
   // ****
   logic        ref_clk, rst_b, instrTick, highOscClk, specialOscClk;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb, nPulse, g;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs, pol, en;
   logic        externalClockPin, go, busy;
   logic [9:0]  otherTimerCount, v, dB, dC, oth;
   logic        gpioABitTwoOut, gpioABitTwoOe, gpioABitFourOut, gpioABitFourOe;
   logic        portABitTwoOut, portABitTwoOe, portABitFourOut, portABitFourOe;
   logic [7:0]  ps;
   int          n_errors = 0, check_count = 0, cyc = 0, s, n, k, mask;
   // Source configurations: control one, control two, expected decrements.
   logic [7:0]  cfgOne [5] = '{8'h01, 8'h01, 8'h01, 8'h09, 8'h19};
   logic [7:0]  cfgTwo [5] = '{8'h08, 8'h28, 8'h38, 8'h28, 8'h08};
   int          cfgCnt [5] = '{3, 5, 5, 7, 9};

   dtp_down_timer #(.ADDR_W(8)) i_dtp_down_timer (.ref_clk, .rst_b,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .instrTick, .highOscClk, .specialOscClk,
      .externalClockPin, .otherTimerCount, .gpioABitTwoOut, .gpioABitTwoOe,
      .gpioABitFourOut, .gpioABitFourOe, .portABitTwoOut, .portABitTwoOe,
      .portABitFourOut, .portABitFourOe);
   dtp_ext_clock_model i_dtp_ext_clock_model (.ref_clk, .rst_b, .go,
      .nPulse, .externalClockPin, .busy);

   // ****
   // Tasks
   // ****
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Write one word; each channel is released at the edge that takes it.
   task automatic wr(input logic [5:0] idx, input logic [7:0] d,
                     input logic [3:0] st = 4'h1);
      s_axi_awaddr  <= {idx, 2'b00};
      s_axi_wdata   <= {24'h0, d};
      s_axi_wstrb   <= st;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      forever begin
         @(posedge ref_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      rs = s_axi_bresp;
   endtask

   // Ready waits for valid, so every read answer must stand for a cycle.
   task automatic rdr(input logic [5:0] idx);
      s_axi_araddr  <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b0;
      forever begin
         @(posedge ref_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) break;
         s_axi_rready <= s_axi_rvalid;
      end
      rd = s_axi_rdata;
      rs = s_axi_rresp;
   endtask

   task automatic rchk(input logic [5:0] idx, input logic [31:0] exp);
      rdr(idx);
      chk(rd, exp);
      chk(32'(rs), 32'(dtp_pkg::RESP_OKAY));
   endtask

   // Source ticks: 0 instruction tick, 1 high and 2 special oscillator.
   task automatic burst(input int kind, input int cnt);
      repeat (cnt) begin
         case (kind)
            0: instrTick <= 1'b1;
            1: highOscClk <= 1'b1;
            default: specialOscClk <= 1'b1;
         endcase
         repeat (kind == 0 ? 1 : 3) @(posedge ref_clk);
         instrTick     <= 1'b0;
         highOscClk    <= 1'b0;
         specialOscClk <= 1'b0;
         repeat (3) @(posedge ref_clk);
      end
   endtask

   task automatic extBurst(input logic [3:0] cnt);
      nPulse <= cnt;
      go     <= 1'b1;
      @(posedge ref_clk);
      go <= 1'b0;
      @(posedge ref_clk);
      while (busy) @(posedge ref_clk);
      repeat (6) @(posedge ref_clk);
   endtask

   // Counter after a number of ticks in mode 0 free, 1 reload, 2 one-shot.
   function automatic logic [9:0] nextv(logic [9:0] x, logic [9:0] rl,
                                        int mode, int cnt);
      repeat (cnt) x = (x != 10'h000) ? x - 10'h001 :
                       (mode == 0) ? 10'h3FF : (mode == 1) ? rl : 10'h000;
      return x;
   endfunction

   task automatic end_sim;
      $display("checks=%0d errors=%0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // ****
   // Clock, watchdog and main sequence
   // ****
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // The run needs well under ten thousand cycles; a hang is cut off.
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_errors++;
         end_sim();
      end
   end

   initial begin
      {rst_b, instrTick, highOscClk, specialOscClk, go} = 5'h00;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
      {s_axi_bready, s_axi_rready} = 2'h3;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      {s_axi_wstrb, nPulse, g} = 12'h0;
      {gpioABitTwoOut, gpioABitTwoOe, gpioABitFourOut, gpioABitFourOe} = 4'h0;
      otherTimerCount = 10'h000;
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge ref_clk);
      void'($urandom(74795));
      rchk(dtp_pkg::IDX_CONTROL_ONE, 32'(dtp_pkg::RST_CONTROL_ONE));
      rchk(dtp_pkg::IDX_CONTROL_TWO, 32'(dtp_pkg::RST_CONTROL_TWO));
      rchk(dtp_pkg::IDX_PULSE_B_CTRL, 32'(dtp_pkg::RST_PULSE_B_CTRL));
      wr(dtp_pkg::IDX_PRESCALE_VAL, 8'h00);
      chk(32'(rs), 32'(dtp_pkg::RESP_OKAY));
      rchk(dtp_pkg::IDX_PRESCALE_VAL, 32'(dtp_pkg::RST_PRESCALE));
      wr(6'h12, 8'h55);
      chk(32'(rs), 32'(dtp_pkg::RESP_SLVERR));
      rdr(6'h3F);
      chk(32'(rs), 32'(dtp_pkg::RESP_SLVERR));
      wr(dtp_pkg::IDX_CONTROL_ONE, 8'h01, 4'h0);
      rchk(dtp_pkg::IDX_CONTROL_ONE, 32'h0);
      // Every rate code; the prescaler phase is tracked from its reset value.
      ps = dtp_pkg::RST_PRESCALE;
      for (int r = 0; r < 8; r++) begin
         wr(dtp_pkg::IDX_DUTY_HIGH, 8'hC0);
         wr(dtp_pkg::IDX_COUNTER_LOW, 8'hFF);
         wr(dtp_pkg::IDX_CONTROL_ONE, 8'h01);
         wr(dtp_pkg::IDX_CONTROL_TWO, {5'b00001, 3'(r - 1)});
         wr(dtp_pkg::IDX_CONTROL_TWO, {5'b00001, r[2:0]});
         wr(dtp_pkg::IDX_CONTROL_TWO, {5'b00000, r[2:0]});
         n = (2 << r) + int'($urandom_range(0, 5));
         mask = (2 << r) - 1;
         k = 0;
         for (int j = 0; j < n; j++) k += (((ps + j) & mask) == mask);
         burst(0, n);
         ps = 8'(ps + n);
         rchk(dtp_pkg::IDX_PRESCALE_VAL, 32'(ps));
         rchk(dtp_pkg::IDX_COUNTER_LOW, 32'(10'h3FF - 10'(k)));
      end
      // Underflow in each mode, then a hold with the run bit clear.
      wr(dtp_pkg::IDX_CONTROL_TWO, 8'h0F);
      wr(dtp_pkg::IDX_CONTROL_TWO, 8'h08);
      for (int m = 0; m < 3; m++) begin
         s = $urandom_range(1, 6);
         n = $urandom_range(s + 2, 12);
         wr(dtp_pkg::IDX_CONTROL_ONE, 8'h00);
         wr(dtp_pkg::IDX_DUTY_HIGH, 8'h00);
         wr(dtp_pkg::IDX_COUNTER_LOW, 8'(s));
         wr(dtp_pkg::IDX_CONTROL_ONE, {5'h0, (m == 2), (m == 1), 1'b1});
         burst(0, n);
         v = nextv(10'(s), 10'(s), m, n);
         rchk(dtp_pkg::IDX_COUNTER_LOW, 32'(v));
         wr(dtp_pkg::IDX_CONTROL_ONE, 8'h00);
         burst(0, 3);
         rchk(dtp_pkg::IDX_COUNTER_LOW, 32'(v));
      end
      // All four sources tick each time; only the selected one counts.
      for (int c = 0; c < 5; c++) begin
         wr(dtp_pkg::IDX_DUTY_HIGH, 8'hC0);
         wr(dtp_pkg::IDX_COUNTER_LOW, 8'hFF);
         wr(dtp_pkg::IDX_CONTROL_ONE, cfgOne[c]);
         wr(dtp_pkg::IDX_CONTROL_TWO, cfgTwo[c]);
         burst(0, 3);
         extBurst(4'h5);
         burst(1, 7);
         burst(2, 9);
         v = 10'h3FF - 10'(cfgCnt[c]);
         rchk(dtp_pkg::IDX_COUNTER_LOW, 32'(v));
      end
      // Random duty, counts and polarities, with equal-value corners.
      for (int i = 0; i < 12; i++) begin
         v   = 10'($urandom_range(0, 1023));
         dB  = 10'($urandom_range(0, 1023));
         dC  = (i == 0) ? v : 10'($urandom_range(0, 1023));
         oth = (i == 1) ? dB : 10'($urandom_range(0, 1023));
         pol = 2'($urandom);
         en  = (i < 2) ? 2'h3 : 2'($urandom);
         g   = 4'($urandom);
         {gpioABitTwoOut, gpioABitTwoOe, gpioABitFourOut, gpioABitFourOe} <= g;
         otherTimerCount <= oth;
         wr(dtp_pkg::IDX_CONTROL_ONE, {en[1], pol[1], 6'h00});
         wr(dtp_pkg::IDX_DUTY_HIGH, {v[9:8], 2'b00, dC[9:8], dB[9:8]});
         wr(dtp_pkg::IDX_COUNTER_LOW, v[7:0]);
         wr(dtp_pkg::IDX_PULSE_B_DUTY, dB[7:0]);
         wr(dtp_pkg::IDX_PULSE_C_DUTY, dC[7:0]);
         wr(dtp_pkg::IDX_PULSE_B_CTRL, {en[0], pol[0], 6'h00});
         rchk(dtp_pkg::IDX_PULSE_B_CTRL, {24'h0, en[0], pol[0], 6'h00});
         repeat (4) @(posedge ref_clk);
         #1;
         chk(32'({portABitTwoOut, portABitTwoOe}),
             32'({en[0] ? (oth <= dB) ^ pol[0] : g[3], en[0] | g[2]}));
         chk(32'({portABitFourOut, portABitFourOe}),
             32'({en[1] ? (v <= dC) ^ pol[1] : g[1], en[1] | g[0]}));
         @(posedge ref_clk);
      end
      end_sim();
   end
endmodule // test_down_timer_with_prescaler_and_pwm
